// [rtl/two_wire_register_slave.sv]
`timescale 1ns/1ps
module two_wire_register_slave
  import two_wire_pkg::*;
(
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe,
  // Address selection
  input wire logic address_select_in,
  input wire logic address_select_en,
  input wire logic alt_address_valid,
  input wire logic [7:0] alt_address_setting,
  // Register map access
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Status
  output logic busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: one sample per serial clock rise, flagged by a toggle.

  logic link_bit_r;
  logic link_tgl_r;

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_bit_r <= 1'b0;
      link_tgl_r <= 1'b0;
    end else begin
      link_bit_r <= serial_data_i;
      link_tgl_r <= ~link_tgl_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain.

  logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic sel_s1_r, sel_s2_r;
  logic bit_s_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
      bit_s_r <= 1'b0;
    end else begin
      tgl_s1_r <= link_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      scl_s1_r <= serial_clk;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= serial_data_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      sel_s1_r <= address_select_in;
      sel_s2_r <= sel_s1_r;
      // The sample is stable for a whole clock high time once the toggle lands.
      bit_s_r <= link_bit_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus events.

  wire bit_ev = tgl_s2_r ^ tgl_s3_r;
  wire scl_high = scl_s2_r & scl_s3_r;
  wire scl_fall = scl_s3_r & ~scl_s2_r;
  wire start_det = scl_high & sda_s3_r & ~sda_s2_r;
  wire stop_det = scl_high & ~sda_s3_r & sda_s2_r;
  wire bus_idle = scl_s2_r & sda_s2_r;
  wire link_bit = bit_s_r;

  // Software setting wins over the pin selection.
  wire [6:0] own_addr = alt_address_valid ? alt_address_setting[7:1]
                      : (address_select_en & sel_s2_r) ? PIN_DEV_ADDR
                      : DEF_DEV_ADDR;

  function automatic logic [15:0] next_ptr(input logic [15:0] p);
    next_ptr = p + 16'h0001;
  endfunction : next_ptr

  //////////////////////////////////////////////////////////////////////////////
  // Byte engine.

  slave_state_t state_r, state_nxt;
  byte_phase_t ph_r, ph_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] fetch_r;
  logic [15:0] ptr_r, ptr_nxt;
  logic oe_r, oe_nxt;
  logic rw_r, rw_nxt;
  logic mack_r, mack_nxt;
  logic rd_q_r;
  reg_req_t req_r, req_nxt;

  wire byte_full = (cnt_r == BYTE_BITS);
  wire addr_match = (rx_r[7:1] == own_addr);

  always_comb begin
    state_nxt = state_r;
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    req_nxt = req_r;
    req_nxt.wr = 1'b0;
    req_nxt.rd = 1'b0;
    req_nxt.addr = ptr_r;
    req_nxt.wdata = rx_r;
    if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = ST_RX;
      ph_nxt = PH_DEV;
      cnt_nxt = CNT_RESET;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (bit_ev && !byte_full) begin
            rx_nxt = {rx_r[6:0], link_bit};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall && byte_full) begin
            cnt_nxt = CNT_RESET;
            state_nxt = ST_ACK;
            oe_nxt = 1'b1;
            case (ph_r)
              PH_DEV: begin
                if (addr_match) begin
                  rw_nxt = rx_r[0];
                  ph_nxt = PH_HI;
                  req_nxt.rd = rx_r[0];
                end else begin
                  state_nxt = ST_IDLE;
                  oe_nxt = 1'b0;
                end
              end
              PH_HI: begin
                ptr_nxt[15:8] = rx_r;
                ph_nxt = PH_LO;
              end
              PH_LO: begin
                ptr_nxt[7:0] = rx_r;
                ph_nxt = PH_DATA;
              end
              default: begin
                req_nxt.wr = 1'b1;
                ptr_nxt = next_ptr(ptr_r);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              state_nxt = ST_TX;
              tx_nxt = {fetch_r[6:0], 1'b0};
              oe_nxt = ~fetch_r[7];
              ptr_nxt = next_ptr(ptr_r);
            end else begin
              state_nxt = ST_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (bit_ev && !byte_full) begin
            cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall) begin
            if (byte_full) begin
              state_nxt = ST_RACK;
              oe_nxt = 1'b0;
              cnt_nxt = CNT_RESET;
              mack_nxt = 1'b0;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (bit_ev) begin
            if (!link_bit) begin
              mack_nxt = 1'b1;
              req_nxt.rd = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
          if (scl_fall && mack_r) begin
            state_nxt = ST_TX;
            mack_nxt = 1'b0;
            tx_nxt = {fetch_r[6:0], 1'b0};
            oe_nxt = ~fetch_r[7];
            ptr_nxt = next_ptr(ptr_r);
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ph_r <= PH_DEV;
      cnt_r <= CNT_RESET;
      rx_r <= BYTE_RESET;
      tx_r <= BYTE_RESET;
      ptr_r <= PTR_RESET;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      req_r <= REQ_RESET;
    end else begin
      state_r <= state_nxt;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      req_r <= req_nxt;
    end
  end

  // Read data is presented by the register map one cycle after the request.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q_r <= 1'b0;
      fetch_r <= BYTE_RESET;
      busy <= 1'b0;
    end else begin
      rd_q_r <= req_r.rd;
      if (rd_q_r) begin
        fetch_r <= reg_rdata;
      end
      busy <= ~bus_idle | (state_r != ST_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs. The clock pin has no driver at all, so it is never held low.

  assign serial_data_oe = oe_r;
  assign serial_data_o = 1'b0;
  assign reg_req = req_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  idle_release_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_IDLE) |-> !oe_r)
    else $error("Data line driven while idle.");

  start_restart_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (start_det && !stop_det) |=> (state_r == ST_RX && cnt_r == CNT_RESET && ph_r == PH_DEV))
    else $error("Start did not restart reception.");

  stop_end_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    stop_det |=> (state_r == ST_IDLE) && !oe_r)
    else $error("Stop did not end the transfer.");

  drive_on_fall_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(oe_r) |-> $past(scl_fall))
    else $error("Data line pulled low outside a clock fall.");

  ack_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_ACK && !scl_fall && !start_det && !stop_det) |=> oe_r)
    else $error("Acknowledge released early.");

  no_match_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RX && ph_r == PH_DEV && scl_fall && byte_full
     && !addr_match && !start_det && !stop_det) |=> (state_r == ST_IDLE) && !oe_r)
    else $error("Foreign address acknowledged.");

  high_first_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RX && ph_r == PH_HI && scl_fall && byte_full
     && !start_det && !stop_det) |=> (ptr_r[15:8] == $past(rx_r)) && (ph_r == PH_LO))
    else $error("High address byte not loaded first.");

  write_step_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(req_r.wr) |-> (ptr_r == req_r.addr + 16'h0001))
    else $error("Pointer did not step after a write.");

  nack_end_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RACK && bit_ev && link_bit && !start_det && !stop_det)
    |=> (state_r == ST_IDLE) ##1 !oe_r [*2])
    else $error("Device kept driving after a nack.");

  low_byte_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RX && ph_r == PH_LO && scl_fall && byte_full
     && !start_det && !stop_det) |=> (ptr_r[7:0] == $past(rx_r)) && (ph_r == PH_DATA))
    else $error("Low address byte not loaded.");

  write_ack_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RX && ph_r == PH_DATA && scl_fall && byte_full
     && !start_det && !stop_det) |=> req_r.wr && oe_r && (state_r == ST_ACK))
    else $error("Write byte not stored and acknowledged.");

  read_next_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_RACK && bit_ev && !link_bit && !start_det && !stop_det)
    |=> req_r.rd && (req_r.addr == ptr_r))
    else $error("Master ack did not fetch the next byte.");

endmodule : two_wire_register_slave

// [rtl/two_wire_pkg.sv]
package two_wire_pkg;

  // Device addresses are held as the upper seven bits of the first byte.
  localparam logic [6:0] DEF_DEV_ADDR = 7'h10;
  localparam logic [6:0] PIN_DEV_ADDR = 7'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } slave_state_t;

  typedef enum logic [1:0] {
    PH_DEV,
    PH_HI,
    PH_LO,
    PH_DATA
  } byte_phase_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  localparam reg_req_t REQ_RESET = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

endpackage : two_wire_pkg

// [dv/two_wire_master.sv]
`timescale 1ns/1ps
module two_wire_master (
  // Link time base
  input wire logic tick,
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge tick);
  endtask : hold
  // The clock idles high between frames.
  task automatic start;
    hold(1);
    sda_low <= 1'b0;
    hold(3);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b1;
    hold(3);
    scl <= 1'b0;
    hold(1);
  endtask : start
  task automatic stop;
    sda_low <= 1'b1;
    hold(3);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b0;
    hold(3);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    hold(3);
    scl <= 1'b1;
    hold(2);
    r = sda;
    hold(2);
    scl <= 1'b0;
    hold(1);
  endtask : bit_io
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask : get_byte
endmodule : two_wire_master

// [dv/test_two_wire_register_slave.sv]
`timescale 1ns/1ps
module test_two_wire_register_slave
  import two_wire_pkg::*;
;
  logic clock, rst_n, tick, scl, m_low, sda, sd_o, sd_oe, busy;
  logic sel_in, sel_en, alt_v;
  logic [7:0] alt_set, reg_rdata, d;
  reg_req_t reg_req;
  logic [15:0] wa[$];
  logic [7:0] wd[$];
  int error_cnt, tests_run, oe_cnt;
  assign sda = ~(m_low | sd_oe);
  two_wire_register_slave dut (.clock(clock), .rst_n(rst_n), .serial_clk(scl),
    .serial_data_i(sda), .serial_data_o(sd_o), .serial_data_oe(sd_oe),
    .address_select_in(sel_in), .address_select_en(sel_en), .alt_address_valid(alt_v),
    .alt_address_setting(alt_set), .reg_req(reg_req), .reg_rdata(reg_rdata), .busy(busy));
  two_wire_master bus (.tick(tick), .scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    tick = 1'b0;
    #3.7;
    forever #24 tick = ~tick;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rd_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : rd_val
  // Register map stand-in: read data is ready the cycle after the request.
  always @(posedge clock) begin
    if (sd_oe === 1'b1) oe_cnt++;
    if (reg_req.rd === 1'b1) reg_rdata <= rd_val(reg_req.addr);
    if (reg_req.wr === 1'b1) begin
      wa.push_back(reg_req.addr);
      wd.push_back(reg_req.wdata);
    end
  end
  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check
  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    bus.put_byte(b, a);
    check({15'h0, exp}, {15'h0, a});
  endtask : send
  task automatic finish_chk;
    bus.stop();
    repeat (20) @(negedge clock);
    check(16'h0, {13'h0, sd_o, busy, sd_oe});
  endtask : finish_chk
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, then a current-location read from the pointer left by reset.
  task automatic reset_read;
    check(16'h0, {13'h0, sd_o, busy, sd_oe});
    bus.start();
    send(8'h21, 1'b1);
    bus.get_byte(1'b0, d);
    check({8'h0, rd_val(PTR_RESET)}, {8'h0, d});
    finish_chk();
  endtask : reset_read
  task automatic write_seq;
    bus.start();
    send(8'h20, 1'b1);
    check(16'h1, {15'h0, busy});
    send(8'h12, 1'b1);
    send(8'h34, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h3c, 1'b1);
    finish_chk();
    check(16'h2, 16'(wa.size()));
    check(16'h1234, wa[0]);
    check({8'h0, 8'ha5}, {8'h0, wd[0]});
    check(16'h1235, wa[1]);
    check({8'h0, 8'h3c}, {8'h0, wd[1]});
  endtask : write_seq
  task automatic read_seq;
    bus.start();
    send(8'h20, 1'b1);
    send(8'h00, 1'b1);
    send(8'h10, 1'b1);
    bus.start();
    send(8'h21, 1'b1);
    bus.get_byte(1'b1, d);
    check({8'h0, rd_val(16'h0010)}, {8'h0, d});
    bus.get_byte(1'b0, d);
    check({8'h0, rd_val(16'h0011)}, {8'h0, d});
    finish_chk();
    bus.start();
    send(8'h21, 1'b1);
    bus.get_byte(1'b0, d);
    check({8'h0, rd_val(16'h0012)}, {8'h0, d});
    finish_chk();
  endtask : read_seq
  task automatic mismatch;
    int n;
    logic r;
    n = oe_cnt;
    bus.start();
    send(8'h40, 1'b0);
    send(8'h20, 1'b0);
    bus.bit_io(1'b1, r);
    bus.bit_io(1'b0, r);
    check(16'(n), 16'(oe_cnt));
    bus.start();
    send(8'h20, 1'b1);
    finish_chk();
  endtask : mismatch
  task automatic addr_sel;
    logic [19:0] tab [7] = '{20'h50020, 20'h40030, 20'hd0030, 20'hc0020,
      20'h90020, 20'hf4444, 20'he4430};
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      {sel_en, sel_in, alt_v} <= tab[i][19:17];
      alt_set <= tab[i][15:8];
      repeat (10) @(posedge clock);
      bus.start();
      send(tab[i][7:0], tab[i][16]);
      finish_chk();
    end
  endtask : addr_sel
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sel_in = 1'b0;
    sel_en = 1'b0;
    alt_v = 1'b0;
    alt_set = 8'h00;
    reg_rdata = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    oe_cnt = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    reset_read();
    write_seq();
    read_seq();
    mismatch();
    addr_sel();
    tally_and_finish();
  end
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_two_wire_register_slave
